// ---- logic/flow_readout_defs.svh ----
`ifndef FLOW_READOUT_DEFS_SVH
`define FLOW_READOUT_DEFS_SVH

// bus address and direction
`define SLAVE_ADDR 7'h50
`define DIR_READ 1'b1

// bit framing
`define BITS_PER_BYTE 4'd8
`define CNT_ZERO 4'd0
`define CNT_ONE 4'd1
`define MSB 7
`define NEXT_MSB 6

// byte sequence of a read
`define IDX_CKS 3'd0
`define IDX_ONE 3'd1
`define IDX_HI 3'd1
`define IDX_LO 3'd2
`define IDX_HI2 3'd3
`define IDX_LO2 3'd4
`define IDX_LAST 3'd5

// data layout
`define FLOW_W 12
`define FLOW_RST 12'h000
`define HI_PAD 4'h0
`define BYTE_ZERO 8'h00

// synchroniser lanes and idle levels (tgl, sda, scl)
`define LANE_SCL 0
`define LANE_SDA 1
`define LANE_TGL 2
`define LANES 3
`define SYNC_RST 3'b011

// pin drive constants
`define DRIVE_LOW 1'b0
`define OE_RELEASE 1'b1
`define OE_DRIVE 1'b0

`endif

// ---- logic/flow_readout_pkg.sv ----
package flow_readout_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_tx,
    st_tx_ack,
    st_wr,
    st_wr_ack,
    st_skip
  } state_t;

endpackage

// ---- logic/scl_bit_capture.sv ----
`timescale 1ns/1ps

// runs on the bus clock itself; each rising edge latches the data line
// and flips a toggle that tells the system domain a new bit is ready
module scl_bit_capture (
  // link clock and reset
  input wire logic scl_clk_in,
  input wire logic reset_in,
  // bus data
  input wire logic sda_in,
  // towards system domain
  output logic bit_out,
  output logic tgl_out
);

  // async reset here: the bus clock may stand still during reset
  always_ff @(posedge scl_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bit_out <= 1'b1;
      tgl_out <= 1'b0;
    end else begin
      bit_out <= sda_in; // R10
      tgl_out <= ~tgl_out;
    end
  end

endmodule

// ---- logic/flow_sensor_i2c_readout.sv ----
`timescale 1ns/1ps
`include "flow_readout_defs.svh"

// Function
// [R01] slave only, works at 100 kHz and 400 kHz bus rates
// [R02] data and clock lines only pulled low or released, never driven high
// [R03] answer only 7-bit address 0x50, ignore all others
// [R04] data falling while clock high is a start
// [R05] data rising while clock high is a stop, back to idle
// [R06] each byte is eight bits then one response bit, low acknowledges
// [R07] after an acknowledge the master sends more or stops
// [R08] after a byte addressed to us, pull data low for response, then release
// [R09] master treats a missing low response as not-acknowledge
// [R10] data sampled on clock rise, changed only while clock low
// [R11] flow value refreshed continuously, no trigger needed
// [R12] every byte shifted most significant bit first
// [R13] master reads with start, address, direction bit one
// [R14] read returns checksum, then flow high byte, then low byte
// [R15] flow is 12-bit unsigned, high byte upper nibble not valid
// [R16] checksum is negated modulo-256 sum of following data bytes
// [R17] master accepts read when checksum plus data sum is zero
// [R18] bytes four and five repeat flow bytes, covered by checksum
// [R19] host converts counts: minus 409, over 3277, times 35 l/min
// [R20] master not-acknowledges last byte then stops
module flow_sensor_i2c_readout (
  // system
  input wire logic clock_in,
  input wire logic reset_in,
  // measurement feed
  input wire logic [`FLOW_W-1:0] flow_count_in,
  input wire logic flow_valid_in,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic scl_out,
  output logic scl_oe_n_out,
  // status
  output logic busy_out
);
  import flow_readout_pkg::*;

  localparam logic [`LANES-1:0] SYNC_INIT = `SYNC_RST;

  logic bit_w;
  logic tgl_w;
  logic [`LANES-1:0] raw_w;
  logic [`LANES-1:0] s1_q;
  logic [`LANES-1:0] s2_q;
  logic [`LANES-1:0] s3_q;
  logic [`LANES-1:0] lvl_q;
  logic [`LANES-1:0] chg_w;
  logic start_ev;
  logic stop_ev;
  logic fall_ev;
  logic rise_ev;

  state_t state_q;
  state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [2:0] idx_q;
  logic [2:0] idx_d;
  logic rw_q;
  logic rw_d;
  logic ack_q;
  logic ack_d;
  logic oe_n_q;
  logic oe_n_d;
  logic [`FLOW_W-1:0] flow_q;
  logic [`FLOW_W-1:0] snap_q;
  logic [`FLOW_W-1:0] snap_d;
  logic sda_q;
  logic scl_q;
  logic scl_oe_n_q;
  logic busy_q;

  logic byte_end_w;
  logic addr_hit_w;
  logic [7:0] hi_w;
  logic [7:0] lo_w;
  logic [7:0] sum_w;
  logic [7:0] cks_w;
  logic [2:0] idx_nx_w;
  logic [2:0] sel_idx_w;
  logic [7:0] tx_byte_w;

  // bus-clock side: bit capture and toggle
  scl_bit_capture u_capture (
    .scl_clk_in(scl_in),
    .reset_in(reset_in),
    .sda_in(sda_in),
    .bit_out(bit_w),
    .tgl_out(tgl_w)
  );

  // three-stage filter per lane; a change counts once stages two and three
  // agree, which keeps glitches on the open-drain lines from firing events
  assign raw_w[`LANE_SCL] = scl_in;
  assign raw_w[`LANE_SDA] = sda_in;
  assign raw_w[`LANE_TGL] = tgl_w;

  generate
    for (genvar i = 0; i < `LANES; i++) begin : g_sync
      always_ff @(posedge clock_in) begin
        if (reset_in) begin
          s1_q[i] <= SYNC_INIT[i];
          s2_q[i] <= SYNC_INIT[i];
          s3_q[i] <= SYNC_INIT[i];
          lvl_q[i] <= SYNC_INIT[i];
        end else begin
          s1_q[i] <= raw_w[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (chg_w[i]) begin
            lvl_q[i] <= s3_q[i];
          end
        end
      end
      assign chg_w[i] = (s2_q[i] == s3_q[i]) && (s3_q[i] != lvl_q[i]);
    end
  endgenerate

  // 25+ system cycles per bus bit even at 400 kHz, so filter lag is harmless
  // data may move in the very step the clock falls; a clock change in that cycle vetoes
  assign start_ev = chg_w[`LANE_SDA] && !s3_q[`LANE_SDA] && lvl_q[`LANE_SCL] // R04 R01
                    && !chg_w[`LANE_SCL];
  assign stop_ev = chg_w[`LANE_SDA] && s3_q[`LANE_SDA] && lvl_q[`LANE_SCL] // R05
                   && !chg_w[`LANE_SCL];
  assign fall_ev = chg_w[`LANE_SCL] && !s3_q[`LANE_SCL];
  // bit_w is stable a full bus period after its toggle, safe to read here
  assign rise_ev = chg_w[`LANE_TGL]; // R10

  // byte framing and address decode
  assign byte_end_w = (cnt_q == `BITS_PER_BYTE); // R06
  assign addr_hit_w = (shift_q[7:1] == `SLAVE_ADDR); // R03

  // read payload from a snapshot so all bytes of one read agree
  assign hi_w = {`HI_PAD, snap_q[`FLOW_W-1:8]}; // R15
  assign lo_w = snap_q[7:0];
  assign sum_w = 8'(hi_w + lo_w + hi_w + lo_w); // R16 R18
  assign cks_w = `BYTE_ZERO - sum_w; // R16
  assign idx_nx_w = (idx_q == `IDX_LAST) ? idx_q : 3'(idx_q + `IDX_ONE);
  assign sel_idx_w = (state_q == st_addr_ack) ? `IDX_CKS : idx_nx_w;
  assign tx_byte_w = (sel_idx_w == `IDX_CKS) ? cks_w : // R14
                     (sel_idx_w == `IDX_HI || sel_idx_w == `IDX_HI2) ? hi_w : // R18
                     (sel_idx_w == `IDX_LO || sel_idx_w == `IDX_LO2) ? lo_w :
                     `BYTE_ZERO;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    idx_d = idx_q;
    rw_d = rw_q;
    ack_d = ack_q;
    oe_n_d = oe_n_q;
    snap_d = snap_q;
    if (stop_ev) begin
      state_d = st_idle; // R05
      oe_n_d = `OE_RELEASE;
    end else if (start_ev) begin
      state_d = st_addr; // R04
      cnt_d = `CNT_ZERO;
      oe_n_d = `OE_RELEASE;
    end else begin
      unique case (state_q)
        st_idle, st_skip: begin
        end
        st_addr: begin
          if (rise_ev && !byte_end_w) begin
            cnt_d = cnt_q + `CNT_ONE;
            shift_d = {shift_q[`NEXT_MSB:0], bit_w}; // R12
          end
          if (fall_ev && byte_end_w) begin
            if (addr_hit_w) begin
              state_d = st_addr_ack;
              oe_n_d = `OE_DRIVE; // R08
              rw_d = shift_q[0]; // R13
              snap_d = flow_q;
            end else begin
              state_d = st_skip; // R03
            end
          end
        end
        st_addr_ack: begin
          if (fall_ev) begin
            cnt_d = `CNT_ZERO;
            if (rw_q == `DIR_READ) begin
              state_d = st_tx;
              idx_d = `IDX_CKS;
              shift_d = tx_byte_w; // R14
              oe_n_d = tx_byte_w[`MSB];
            end else begin
              state_d = st_wr;
              oe_n_d = `OE_RELEASE; // R08
            end
          end
        end
        st_tx: begin
          if (rise_ev && !byte_end_w) begin
            cnt_d = cnt_q + `CNT_ONE;
          end
          if (fall_ev && byte_end_w) begin
            state_d = st_tx_ack; // R06
            oe_n_d = `OE_RELEASE;
          end else if (fall_ev) begin
            shift_d = {shift_q[`NEXT_MSB:0], 1'b0}; // R12
            oe_n_d = shift_q[`NEXT_MSB]; // R02 R10
          end
        end
        st_tx_ack: begin
          if (rise_ev) begin
            ack_d = !bit_w; // R06
          end
          if (fall_ev && ack_q) begin
            state_d = st_tx; // R07
            cnt_d = `CNT_ZERO;
            idx_d = idx_nx_w;
            shift_d = tx_byte_w;
            oe_n_d = tx_byte_w[`MSB];
          end else if (fall_ev) begin
            state_d = st_skip; // R20 R09
          end
        end
        st_wr: begin
          if (rise_ev && !byte_end_w) begin
            cnt_d = cnt_q + `CNT_ONE;
          end
          if (fall_ev && byte_end_w) begin
            state_d = st_wr_ack;
            oe_n_d = `OE_DRIVE; // R08
          end
        end
        st_wr_ack: begin
          if (fall_ev) begin
            state_d = st_wr;
            cnt_d = `CNT_ZERO;
            oe_n_d = `OE_RELEASE; // R08
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_q <= st_idle;
      cnt_q <= `CNT_ZERO;
      shift_q <= `BYTE_ZERO;
      idx_q <= `IDX_CKS;
      rw_q <= `DIR_READ;
      ack_q <= 1'b0;
      oe_n_q <= `OE_RELEASE;
      snap_q <= `FLOW_RST;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      idx_q <= idx_d;
      rw_q <= rw_d;
      ack_q <= ack_d;
      oe_n_q <= oe_n_d;
      snap_q <= snap_d;
    end
  end

  // latest measurement always held, so a read never waits on a conversion
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      flow_q <= `FLOW_RST;
    end else if (flow_valid_in) begin
      flow_q <= flow_count_in; // R11
    end
  end

  // pins: open drain only; clock is never stretched
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sda_q <= `DRIVE_LOW;
      scl_q <= `DRIVE_LOW;
      scl_oe_n_q <= `OE_RELEASE;
      busy_q <= 1'b0;
    end else begin
      sda_q <= `DRIVE_LOW; // R02
      scl_q <= `DRIVE_LOW;
      scl_oe_n_q <= `OE_RELEASE; // R02
      busy_q <= (state_d != st_idle) && (state_d != st_skip);
    end
  end

  assign sda_out = sda_q;
  assign sda_oe_n_out = oe_n_q;
  assign scl_out = scl_q;
  assign scl_oe_n_out = scl_oe_n_q;
  assign busy_out = busy_q;

  // checks
  default clocking cb_sys @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  sequence s_addr_done;
    fall_ev && !stop_ev && !start_ev && state_q == st_addr && byte_end_w;
  endsequence

  sequence s_read_begin;
    fall_ev && !stop_ev && !start_ev && state_q == st_addr_ack && rw_q;
  endsequence

  sequence s_tx_bit;
    fall_ev && !stop_ev && !start_ev && state_q == st_tx && !byte_end_w;
  endsequence

  property p_open_drain;
    sda_out == 1'b0 && scl_out == 1'b0 && scl_oe_n_out == 1'b1;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high"); // R02

  property p_addr_miss;
    s_addr_done ##0 !addr_hit_w |=> state_q == st_skip && sda_oe_n_out;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered"); // R03

  property p_addr_ack;
    s_addr_done ##0 addr_hit_w |=> !sda_oe_n_out && state_q == st_addr_ack;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked"); // R08

  property p_start;
    start_ev && !stop_ev |=> state_q == st_addr && cnt_q == 4'd0;
  endproperty
  a_start: assert property (p_start) else $error("start not taken"); // R04

  property p_stop;
    stop_ev |=> state_q == st_idle && sda_oe_n_out && !busy_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not idle"); // R05

  property p_sda_change;
    $changed(sda_oe_n_out) |-> $past(fall_ev || start_ev || stop_ev);
  endproperty
  a_sda_change: assert property (p_sda_change) else $error("sda moved with scl high"); // R10

  property p_read_first;
    s_read_begin |=> shift_q == $past(cks_w) && idx_q == 3'd0 && state_q == st_tx;
  endproperty
  a_read_first: assert property (p_read_first) else $error("checksum not first"); // R14

  property p_msb_first;
    s_tx_bit |=> sda_oe_n_out == $past(shift_q[6]) && shift_q[0] == 1'b0;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bit order wrong"); // R12

  property p_checksum;
    s_read_begin |=> 8'(shift_q + hi_w + lo_w + hi_w + lo_w) == 8'h00;
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum does not cancel"); // R16

  property p_hi_pad;
    state_q == st_tx && $past(state_q) == st_tx_ack && idx_q[0] |-> shift_q[7:4] == 4'h0;
  endproperty
  a_hi_pad: assert property (p_hi_pad) else $error("high nibble not zero"); // R15

  property p_byte_end;
    fall_ev && !stop_ev && !start_ev && state_q == st_tx && byte_end_w
      |=> sda_oe_n_out && state_q == st_tx_ack;
  endproperty
  a_byte_end: assert property (p_byte_end) else $error("line held in response bit"); // R06

  property p_repeat;
    fall_ev && !stop_ev && !start_ev && state_q == st_tx_ack && ack_q && idx_q == 3'd2
      |=> shift_q == hi_w && idx_q == 3'd3;
  endproperty
  a_repeat: assert property (p_repeat) else $error("fourth byte not flow high"); // R18

  property p_nack;
    fall_ev && !stop_ev && !start_ev && state_q == st_tx_ack && !ack_q
      |=> state_q == st_skip ##1 sda_oe_n_out;
  endproperty
  a_nack: assert property (p_nack) else $error("sending after nack"); // R20

  property p_flow;
    flow_valid_in |=> flow_q == $past(flow_count_in);
  endproperty
  a_flow: assert property (p_flow) else $error("measurement not held"); // R11

endmodule

// ---- bench/i2c_master_model.sv ----
`timescale 1ns/1ps

// bus master; clock stands high between frames, lines released to pull-up
module i2c_master_model (
  // bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  localparam realtime Q = 62.5;

  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  // also serves as repeated start when clock is low on entry
  task automatic start_c();
    sda_out = 1'b1;
    #(Q) scl_out = 1'b1;
    #(Q) sda_out = 1'b0;
    #(Q) scl_out = 1'b0;
  endtask

  // data only changes while clock low
  task automatic xfer_bit(input logic b, output logic seen);
    sda_out = b;
    #(Q) scl_out = 1'b1;
    #(Q/2) seen = sda_in;
    #(Q/2) scl_out = 1'b0;
  endtask

  // a high response seen means not-acknowledge
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack_seen);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(tx[i], s);
      rx[i] = s;
    end
    xfer_bit(ack_in, ack_seen);
  endtask

  task automatic stop_c();
    sda_out = 1'b0;
    #(Q) scl_out = 1'b1;
    #(Q) sda_out = 1'b1;
    #(Q);
  endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`include "flow_readout_defs.svh"

module testbench;
  logic clock_in, reset_in, flow_valid_in;
  logic [`FLOW_W-1:0] flow_count_in, flow_q;
  logic sda_out, sda_oe_n_out, scl_out, scl_oe_n_out, busy_out;
  logic m_scl, m_sda;
  wire sda_w = m_sda & (sda_oe_n_out | sda_out);
  wire scl_w = m_scl & (scl_oe_n_out | scl_out);
  int fails, n_compared, seed;

  flow_sensor_i2c_readout u_flow_sensor_i2c_readout (
    .clock_in(clock_in), .reset_in(reset_in),
    .flow_count_in(flow_count_in), .flow_valid_in(flow_valid_in),
    .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .scl_out(scl_out), .scl_oe_n_out(scl_oe_n_out), .busy_out(busy_out)
  );

  i2c_master_model u_i2c_master_model (.sda_in(sda_w), .scl_out(m_scl), .sda_out(m_sda));

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_int(input string what, input logic signed [31:0] exp,
                           input logic signed [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // host scaling of a count to hundredths of a litre per minute
  function automatic logic signed [31:0] centi_lpm(input logic [11:0] c);
    if ($isunknown(c)) centi_lpm = 'x;
    else centi_lpm = int'((real'(c) - 409.0) * 3500.0 / 3277.0);
  endfunction

  task automatic check_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // byte k of a read; later repeats are our chosen reading of the optional bytes
  function automatic logic [7:0] exp_byte(input logic [11:0] f, input int k);
    logic [7:0] hi, lo;
    hi = {4'h0, f[11:8]};
    lo = f[7:0];
    case (k)
      0: exp_byte = 8'h00 - hi - lo - hi - lo;
      1, 3: exp_byte = hi;
      2, 4: exp_byte = lo;
      default: exp_byte = 8'h00;
    endcase
  endfunction

  // junk on the count afterwards must not disturb the stored value
  task automatic feed(input logic [11:0] f);
    @(posedge clock_in);
    #1 flow_count_in = f;
    flow_valid_in = 1'b1;
    @(posedge clock_in);
    #1 flow_valid_in = 1'b0;
    flow_count_in = 12'($random(seed));
    flow_q = f;
  endtask

  task automatic frame(input logic [6:0] addr, input logic dir, input int nb,
                       input int nack_at, input logic do_stop);
    logic [7:0] rx, sum, tx;
    logic a, ours;
    int k;
    logic [11:0] got;
    ours = (addr == 7'h50);
    sum = 8'h00;
    got = 12'h000;
    // bus edges kept off the system clock edges
    @(posedge clock_in);
    #1;
    u_i2c_master_model.start_c();
    u_i2c_master_model.xfer_byte({addr, dir}, 1'b1, rx, a);
    check_bit("address ack", !ours, a);
    check_bit("busy", ours, busy_out);
    for (k = 0; k < nb; k++) begin
      tx = dir ? 8'hff : 8'($random(seed));
      u_i2c_master_model.xfer_byte(tx, dir ? (k >= nack_at) : 1'b1, rx, a);
      if (!dir) check_bit("write ack", !ours, a);
      else check_byte("read byte", (ours && k <= nack_at) ? exp_byte(flow_q, k) : 8'hff, rx);
      sum += rx;
      if (k == 1) got[11:8] = rx[3:0];
      if (k == 2) got[7:0] = rx;
    end
    if (dir && ours && nb == 5 && nack_at == 4) check_byte("sum", 8'h00, sum);
    if (dir && ours && nb > 2 && nack_at >= 2) begin
      check_int("flow scaled", centi_lpm(flow_q), centi_lpm(got));
    end
    if (do_stop) begin
      u_i2c_master_model.stop_c();
      k = 0;
      while (busy_out !== 1'b0 && k < 20) begin
        @(posedge clock_in);
        k++;
      end
      check_bit("busy after stop", 1'b0, busy_out);
      check_bit("data released", 1'b1, sda_oe_n_out);
    end
  endtask

  initial begin
    #400000;
    fails++;
    $display("mismatch timeout expected done seen hang");
    report_and_stop();
  end

  initial begin
    int nb;
    seed = 75;
    fails = 0;
    n_compared = 0;
    reset_in = 1'b1;
    flow_valid_in = 1'b0;
    flow_count_in = 12'h000;
    flow_q = 12'h000;
    repeat (12) @(posedge clock_in);
    #1;
    check_bit("data enable", 1'b1, sda_oe_n_out);
    check_bit("clock enable", 1'b1, scl_oe_n_out);
    check_bit("data level", 1'b0, sda_out);
    check_bit("clock level", 1'b0, scl_out);
    check_bit("busy reset", 1'b0, busy_out);
    reset_in = 1'b0;
    repeat (4) @(posedge clock_in);
    frame(7'h50, 1'b1, 3, 2, 1'b1);
    feed(12'hfff);
    frame(7'h50, 1'b1, 5, 4, 1'b1);
    feed(12'h199);
    frame(7'h50, 1'b1, 6, 5, 1'b1);
    frame(7'h51, 1'b1, 2, 1, 1'b1);
    frame(7'h50, 1'b0, 2, 1, 1'b1);
    frame(7'h50, 1'b1, 3, 0, 1'b1);
    frame(7'h50, 1'b1, 2, 1, 1'b0);
    frame(7'h50, 1'b1, 5, 4, 1'b1);
    for (int i = 0; i < 8; i++) begin
      feed(12'($random(seed)));
      nb = 1 + ($unsigned($random(seed)) % 6);
      frame(i[0] ? 7'h50 : 7'($random(seed)), i[1] | i[0], nb, nb - 1, 1'b1);
    end
    report_and_stop();
  end
endmodule
